// file: shared/sec_pkg.sv
// Purpose: Shared constants and types for the statistics unit control block.
// Assumes: One 20 MHz clock, AHB-Lite register access, 32-bit words.
// Notes:   Register offsets are byte addresses of aligned words.

// ***************************************************************
// Package
// ***************************************************************
package sec_pkg;

  localparam int unsigned WORD_W = 32;

  // Shadowed registers.
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FOCUS_BUF_OFS = 12'h004;
  localparam logic [11:0] EXPO_BUF_OFS = 12'h008;
  // Busy-locked configuration words start here, one word each.
  localparam logic [11:0] CFG_BASE_OFS = 12'h00C;
  localparam int unsigned CFG_WORDS = 14;

  // Word index of each busy-locked configuration register.
  localparam int unsigned CFG_FOCUS_PAXEL_SIZE = 0;
  localparam int unsigned CFG_FOCUS_PAXEL_COUNT = 1;
  localparam int unsigned CFG_FOCUS_PAXEL_START = 2;
  localparam int unsigned CFG_FOCUS_FILTER_HSTART = 3;
  localparam int unsigned CFG_FOCUS_COEF_SET0 = 4;
  localparam int unsigned CFG_FOCUS_COEF_SET1 = 5;
  localparam int unsigned CFG_EXPOSURE_WINDOW_SIZE = 6;
  localparam int unsigned CFG_EXPOSURE_WINDOW_START = 7;
  localparam int unsigned CFG_EXPOSURE_BLACK_ROW = 8;
  localparam int unsigned CFG_EXPOSURE_SUBSAMPLE = 9;
  localparam int unsigned CFG_SATURATION_LIMIT = 10;
  localparam int unsigned CFG_MEMORY_READ_ADDRESS = 11;
  localparam int unsigned CFG_MEMORY_LINE_OFFSET = 12;
  localparam int unsigned CFG_MEMORY_FRAME_SIZE = 13;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  // Busy bits are read-only; bits 31:21 are reserved.
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h001F_E7FF;

  typedef struct packed {
    logic [10:0] reserved;
    logic [7:0] median_threshold;
    logic exposure_busy;
    logic focus_busy;
    logic memory_fetch_enable;
    logic input_width_select;
    logic focus_value_mode;
    logic [1:0] colour_position;
    logic exposure_companding_enable;
    logic focus_companding_enable;
    logic focus_median_enable;
    logic input_source_select;
    logic exposure_enable;
    logic focus_enable;
  } sec_ctrl_s;

endpackage

// file: hdl/sec_stats_engine_control.sv
// Purpose: Control and sequencing of the focus and exposure statistics engines.
// Assumes: hclk at 20 MHz; sensor frame start arrives asynchronously on a pin.
// Notes:   Statistics arithmetic lives outside; it reports completion here.
`timescale 1ns/1ns

module sec_stats_engine_control #(
  parameter int unsigned ADDR_W = 12 // Decoded address bits.
) (
  input wire logic hclk, // Subsystem clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic clk_en, // Freezes all state while low.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic hreadyout, // AHB slave ready.
  output logic hresp, // AHB response, always OKAY.
  output logic [31:0] hrdata, // AHB read data.
  input wire logic sensor_frame_start, // Sensor controller frame start pin.
  input wire logic focus_done, // Focus engine finished its frame.
  input wire logic exposure_done, // Exposure engine finished its frame.
  output logic frame_start, // Start of frame pulse to the engines.
  output logic memory_fetch_start, // Launch one frame fetch from memory.
  output logic focus_run, // Focus engine busy with a frame.
  output logic exposure_run, // Exposure engine busy with a frame.
  output logic stats_irq, // Merged end-of-frame interrupt pulse.
  output logic stats_dma_event, // Merged end-of-frame DMA event pulse.
  output sec_pkg::sec_ctrl_s ctrl_work, // Working copy of control.
  output logic [31:0] focus_buf_work, // Working focus buffer start.
  output logic [31:0] exposure_buf_work, // Working exposure buffer start.
  output logic [sec_pkg::CFG_WORDS-1:0][31:0] cfg_out // Locked config.
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  sec_pkg::sec_ctrl_s ctrl_reg;
  logic [31:0] focus_buf_reg;
  logic [31:0] exposure_buf_reg;
  logic focus_busy_reg;
  logic exposure_busy_reg;
  logic wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic wr_en;
  logic [4:0] wr_idx;
  logic unit_busy;
  logic mem_mode;
  logic mem_launch;
  logic sof;
  logic sensor_sof_evt;
  logic focus_fin;
  logic exposure_fin;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;

  // Word index of an address: 0..2 shadowed, 3..16 locked, 31 unmapped.
  function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a >> 2;
    if (a[1:0] != 2'h0 || w >= ADDR_W'(3 + sec_pkg::CFG_WORDS)) begin
      return 5'h1F;
    end
    return w[4:0];
  endfunction

  // ***************************************************************
  // Bus slave
  // ***************************************************************
  // Writes land at the end of the data phase. The master never overlaps
  // a new address phase with a data phase, so reads captured in the
  // address phase never miss a pending write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_reg <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_reg <= hwrite;
        wr_addr_reg <= haddr[ADDR_W-1:0];
        if (!hwrite) begin
          hrdata <= rd_word;
        end
      end
    end
  end

  // Zero wait states and never an error response.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign wr_en = wr_pend_reg && clk_en;
  assign wr_idx = reg_index(wr_addr_reg);

  always_comb begin
    logic [4:0] ri;
    sec_pkg::sec_ctrl_s c;
    ri = reg_index(haddr[ADDR_W-1:0]);
    c = ctrl_reg;
    c.focus_busy = focus_busy_reg;
    c.exposure_busy = exposure_busy_reg;
    rd_word = 32'h0000_0000;
    if (ri == 5'(sec_pkg::CTRL_OFS >> 2)) begin
      rd_word = c;
    end else if (ri == 5'(sec_pkg::FOCUS_BUF_OFS >> 2)) begin
      rd_word = focus_buf_reg;
    end else if (ri == 5'(sec_pkg::EXPO_BUF_OFS >> 2)) begin
      rd_word = exposure_buf_reg;
    end else if (ri != 5'h1F) begin
      rd_word = cfg_out[ri - 5'(sec_pkg::CFG_BASE_OFS >> 2)];
    end
  end

  // ***************************************************************
  // Shadowed registers
  // ***************************************************************
  // Software's write of the fetch bit wins over the hardware clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= sec_pkg::WORD_RESET;
      focus_buf_reg <= sec_pkg::WORD_RESET;
      exposure_buf_reg <= sec_pkg::WORD_RESET;
    end else if (clk_en) begin
      if (mem_launch) begin
        ctrl_reg.memory_fetch_enable <= 1'b0;
      end
      if (wr_en && wr_idx == 5'(sec_pkg::CTRL_OFS >> 2)) begin
        ctrl_reg <= hwdata & sec_pkg::CTRL_WRITE_MASK;
      end
      if (wr_en && wr_idx == 5'(sec_pkg::FOCUS_BUF_OFS >> 2)) begin
        focus_buf_reg <= hwdata;
      end
      if (wr_en && wr_idx == 5'(sec_pkg::EXPO_BUF_OFS >> 2)) begin
        exposure_buf_reg <= hwdata;
      end
    end
  end

  // Working copies change only at a start of frame.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_work <= sec_pkg::WORD_RESET;
      focus_buf_work <= sec_pkg::WORD_RESET;
      exposure_buf_work <= sec_pkg::WORD_RESET;
    end else if (clk_en && sof) begin
      ctrl_work <= ctrl_reg;
      focus_buf_work <= focus_buf_reg;
      exposure_buf_work <= exposure_buf_reg;
    end
  end

  AST_SHADOW_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !(clk_en && sof) |=> $stable(ctrl_work) && $stable(focus_buf_work))
    else $error("Working copy changed outside a frame start.");

  // ***************************************************************
  // Busy-locked configuration
  // ***************************************************************
  assign unit_busy = focus_busy_reg || exposure_busy_reg;

  generate
    for (genvar g = 0; g < sec_pkg::CFG_WORDS; g++) begin : g_cfg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg_out[g] <= sec_pkg::WORD_RESET;
        end else if (clk_en && wr_en && !unit_busy &&
                     wr_idx == 5'(g + (sec_pkg::CFG_BASE_OFS >> 2))) begin
          cfg_out[g] <= hwdata;
        end
      end
    end
  endgenerate

  AST_LOCKED_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    unit_busy |=> $stable(cfg_out))
    else $error("Locked configuration changed while busy.");

  AST_UNLOCKED_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_en && !unit_busy
     && wr_idx == 5'(sec_pkg::CFG_BASE_OFS >> 2))
    |=> cfg_out[0] == $past(hwdata))
    else $error("Idle write to a locked register was lost.");

  // ***************************************************************
  // Frame start sources
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= sensor_frame_start;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign sensor_sof_evt = sync2_reg && !sync3_reg;
  assign mem_mode = ctrl_reg.input_source_select;
  // A fetch is launched only when idle, so one request yields one frame.
  assign mem_launch = mem_mode && ctrl_reg.memory_fetch_enable
                      && !unit_busy
                      && (ctrl_reg.focus_enable || ctrl_reg.exposure_enable);
  // Sensor frames are ignored entirely while memory input is selected.
  assign sof = mem_mode ? mem_launch : sensor_sof_evt;

  AST_CONT_TIMING: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !mem_mode && $rose(sync2_reg)) |=> frame_start)
    else $error("Sensor frame start did not start a frame.");

  AST_ONE_SHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && mem_launch && !(wr_en && wr_idx == 5'h00))
    |=> !ctrl_reg.memory_fetch_enable ##1 !mem_launch)
    else $error("One fetch request launched more than one frame.");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_start <= 1'b0;
      memory_fetch_start <= 1'b0;
    end else if (clk_en) begin
      frame_start <= sof;
      memory_fetch_start <= mem_launch;
    end
  end

  // ***************************************************************
  // Busy flags and completion events
  // ***************************************************************
  assign focus_fin = focus_done && focus_busy_reg;
  assign exposure_fin = exposure_done && exposure_busy_reg;

  // Enables are sampled only at frame start, so a clear written mid-frame
  // lets the frame finish. A new frame start beats a same-cycle finish.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      focus_busy_reg <= 1'b0;
      exposure_busy_reg <= 1'b0;
    end else if (clk_en) begin
      if (sof) begin
        focus_busy_reg <= ctrl_reg.focus_enable;
      end else if (focus_fin) begin
        focus_busy_reg <= 1'b0;
      end
      if (sof) begin
        exposure_busy_reg <= ctrl_reg.exposure_enable;
      end else if (exposure_fin) begin
        exposure_busy_reg <= 1'b0;
      end
    end
  end

  AST_BUSY_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && sof) |=> (focus_busy_reg == $past(ctrl_reg.focus_enable))
    && (exposure_busy_reg == $past(ctrl_reg.exposure_enable)))
    else $error("Busy flags do not follow enables at frame start.");

  AST_BUSY_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && focus_fin && !sof) |=> !focus_busy_reg)
    else $error("Focus busy did not clear at frame completion.");

  AST_RUN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (focus_busy_reg && !focus_done && !sof) |=> focus_busy_reg)
    else $error("Focus engine stopped before its frame ended.");

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      focus_run <= 1'b0;
      exposure_run <= 1'b0;
    end else if (clk_en) begin
      focus_run <= focus_busy_reg || (sof && ctrl_reg.focus_enable);
      exposure_run <= exposure_busy_reg
                      || (sof && ctrl_reg.exposure_enable);
    end
  end

  // Two completions in one cycle give a single merged pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stats_irq <= 1'b0;
      stats_dma_event <= 1'b0;
    end else if (clk_en) begin
      stats_irq <= focus_fin || exposure_fin;
      stats_dma_event <= focus_fin || exposure_fin;
    end
  end

  AST_MERGED_EVENT: assert property (@(posedge hclk) disable iff (!hresetn)
    stats_irq |-> stats_dma_event && $past(focus_fin || exposure_fin))
    else $error("Merged event without an engine completion.");

  AST_EVENT_RAISED: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && exposure_fin) |=> stats_irq && stats_dma_event)
    else $error("Engine completion produced no interrupt or DMA event.");

endmodule // sec_stats_engine_control

// file: tb/sec_engine_model.sv
// Purpose: Stand-in for one statistics engine that reports frame completion.
// Assumes: A frame begins on the control block's frame start pulse.
// Notes:   Latency is chosen per frame; 1 answers promptly, larger is slow.
`timescale 1ns/1ns

// ***************************************************************
// Engine completion model
// ***************************************************************
module sec_engine_model (
  input wire logic hclk, // Subsystem clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic start, // Frame start from the control block.
  input wire logic run, // This engine was granted the frame.
  input wire logic [7:0] lat, // Cycles from start to completion.
  output logic done // One-cycle completion pulse.
);
  logic [7:0] cnt_reg;

  // Only a granted engine counts, so a disabled one never reports.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 8'h0;
      done <= 1'h0;
    end else begin
      done <= 1'h0;
      if (start && run) begin
        cnt_reg <= lat;
      end else if (cnt_reg != 8'h0) begin
        cnt_reg <= cnt_reg - 8'h1;
        done <= (cnt_reg == 8'h1);
      end
    end
  end
endmodule // sec_engine_model

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the statistics unit control block.
// Assumes: Zero-wait AHB-Lite slave; two engine models finish frames.
// Notes:   Reads queue their expected word; a monitor compares them.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb_top;
  // ***************************************************************
  // Signals and models
  // ***************************************************************
  logic hclk, hresetn, hsel, hwrite, sensor_frame_start;
  logic rd_pend = 1'h0;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, focus_buf_work, exposure_buf_work;
  logic [1:0] htrans;
  logic hreadyout, hresp, focus_done, exposure_done, frame_start;
  logic memory_fetch_start, focus_run, exposure_run, stats_irq;
  logic stats_dma_event;
  sec_pkg::sec_ctrl_s ctrl_work, c;
  logic [sec_pkg::CFG_WORDS-1:0][31:0] cfg_out;
  logic [7:0] focus_lat, exposure_lat;
  logic [31:0] exp_q[$];
  logic [31:0] seed, v, rd_exp;
  int errors, checks_done, cycles, irq_cnt, dma_cnt, fs_cnt, mf_cnt;

  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end

  sec_stats_engine_control dut_u (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'h1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sensor_frame_start(sensor_frame_start), .focus_done(focus_done),
    .exposure_done(exposure_done), .frame_start(frame_start),
    .memory_fetch_start(memory_fetch_start), .focus_run(focus_run),
    .exposure_run(exposure_run), .stats_irq(stats_irq),
    .stats_dma_event(stats_dma_event), .ctrl_work(ctrl_work),
    .focus_buf_work(focus_buf_work), .exposure_buf_work(exposure_buf_work),
    .cfg_out(cfg_out));
  sec_engine_model focus_m (.hclk(hclk), .hresetn(hresetn),
    .start(frame_start), .run(focus_run), .lat(focus_lat),
    .done(focus_done));
  sec_engine_model expo_m (.hclk(hclk), .hresetn(hresetn),
    .start(frame_start), .run(exposure_run), .lat(exposure_lat),
    .done(exposure_done));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read data is judged at the edge that closes its data phase.
  always @(posedge hclk) begin
    cycles++;
    irq_cnt += int'(stats_irq);
    dma_cnt += int'(stats_dma_event);
    fs_cnt += int'(frame_start);
    mf_cnt += int'(memory_fetch_start);
    if (rd_pend && hreadyout) begin
      rd_exp = exp_q.pop_front();
      `CHK(hrdata, rd_exp)
      `CHK(hresp, 1'h0)
    end
    if (hreadyout) rd_pend <= hsel && htrans[1] && !hwrite;
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end

  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'h0, 32'h0);
  endtask

  // The pin is asynchronous; four cycles outlast the synchroniser.
  task sof();
    sensor_frame_start <= 1'h1;
    repeat (4) @(posedge hclk);
    sensor_frame_start <= 1'h0;
    repeat (6) @(posedge hclk);
  endtask

  task wait_irq(input int n);
    repeat (200) if (irq_cnt < n) @(posedge hclk);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  initial begin
    seed = 32'h60;
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    sensor_frame_start = 1'h0;
    focus_lat = 8'h1;
    exposure_lat = 8'h1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(sec_pkg::CTRL_OFS, 32'h0);
    for (int i = 0; i < sec_pkg::CFG_WORDS; i++) begin
      v = rnd();
      wr(sec_pkg::CFG_BASE_OFS + 12'(i * 4), v);
      rd(sec_pkg::CFG_BASE_OFS + 12'(i * 4), v);
      `CHK(cfg_out[i], v)
    end
    wr(12'h100, rnd());
    rd(12'h100, 32'h0);
    $display("test registers done");

    wr(sec_pkg::CFG_BASE_OFS, 32'hA5A5_0F0F);
    focus_lat <= 8'h28;
    v = rnd();
    c = '0;
    c.focus_median_enable = 1'h1;
    c.median_threshold = v[7:0];
    v = rnd();
    wr(sec_pkg::FOCUS_BUF_OFS, v);
    rd(sec_pkg::FOCUS_BUF_OFS, v);
    c.focus_enable = 1'h1;
    wr(sec_pkg::CTRL_OFS, 32'(c) | 32'hFFE0_1800);
    rd(sec_pkg::CTRL_OFS, 32'(c));
    `CHK(focus_buf_work, 32'h0)
    sof();
    `CHK(focus_buf_work, v)
    `CHK(focus_run, 1'h1)
    `CHK(exposure_run, 1'h0)
    rd(sec_pkg::CTRL_OFS, 32'(c) | 32'h800);
    wr(sec_pkg::CFG_BASE_OFS, rnd());
    rd(sec_pkg::CFG_BASE_OFS, 32'hA5A5_0F0F);
    c.focus_enable = 1'h0;
    wr(sec_pkg::CTRL_OFS, 32'(c));
    `CHK(focus_run, 1'h1)
    `CHK(ctrl_work.focus_enable, 1'h1)
    wait_irq(1);
    repeat (2) @(posedge hclk);
    `CHK(irq_cnt, 1)
    `CHK(dma_cnt, 1)
    `CHK(focus_run, 1'h0)
    rd(sec_pkg::CTRL_OFS, 32'(c));
    wr(sec_pkg::CFG_BASE_OFS, 32'h0F0F_A5A5);
    rd(sec_pkg::CFG_BASE_OFS, 32'h0F0F_A5A5);
    sof();
    `CHK(focus_run, 1'h0)
    $display("test continuous done");

    focus_lat <= 8'h10;
    exposure_lat <= 8'h10;
    v = rnd();
    wr(sec_pkg::EXPO_BUF_OFS, v);
    c.focus_enable = 1'h1;
    c.exposure_enable = 1'h1;
    wr(sec_pkg::CTRL_OFS, 32'(c));
    sof();
    `CHK(exposure_run, 1'h1)
    `CHK(exposure_buf_work, v)
    wait_irq(2);
    repeat (20) @(posedge hclk);
    `CHK(irq_cnt, 2)
    exposure_lat <= 8'h30;
    sof();
    wait_irq(3);
    `CHK(exposure_run, 1'h1)
    wait_irq(4);
    repeat (4) @(posedge hclk);
    `CHK(irq_cnt, 4)
    `CHK(dma_cnt, 4)
    $display("test merged done");

    focus_lat <= 8'h5;
    c = '0;
    c.input_source_select = 1'h1;
    c.focus_enable = 1'h1;
    c.memory_fetch_enable = 1'h1;
    wr(sec_pkg::CTRL_OFS, 32'(c));
    wait_irq(5);
    repeat (20) @(posedge hclk);
    `CHK(mf_cnt, 1)
    v = fs_cnt;
    sof();
    `CHK(fs_cnt, int'(v))
    c.memory_fetch_enable = 1'h0;
    rd(sec_pkg::CTRL_OFS, 32'(c));
    c.memory_fetch_enable = 1'h1;
    wr(sec_pkg::CTRL_OFS, 32'(c));
    wait_irq(6);
    repeat (20) @(posedge hclk);
    `CHK(mf_cnt, 2)
    `CHK(irq_cnt, 6)
    $display("test one shot done");
    end_sim();
  end
endmodule // tb_top
